// >>> logic/charger_regs_pkg.sv
package charger_regs_pkg;

    // register offsets on the serial control interface
    localparam logic [7:0] OFFSET_INPUT_LIMIT   = 8'h0D;
    localparam logic [7:0] OFFSET_BATTERY       = 8'h0E;
    localparam logic [7:0] OFFSET_SYSTEM        = 8'h0F;
    localparam logic [7:0] OFFSET_INPUT_VOLTAGE = 8'h11;
    localparam logic [7:0] OFFSET_CHARGE        = 8'h12;

    // field layout shared by all five registers: flag (reserved zero at 0F and 12) in bit 7, code below
    localparam int         FLAG_BIT             = 7;
    localparam int         CODE_WIDTH           = 7;

    // threshold field codes
    localparam logic [6:0] THRESHOLD_RESET_CODE = 7'h12;
    localparam logic [6:0] THRESHOLD_CLAMP_CODE = 7'h0D;
    localparam logic       SELECT_RESET         = 1'h0;

    // converter results before the first conversion, and the charge current shown during a short
    localparam logic [6:0] RESULT_RESET_CODE    = 7'h00;
    localparam logic [6:0] CURRENT_SHORT_CODE   = 7'h00;

    // value returned for unmapped offsets and reserved bits
    localparam logic [7:0] UNMAPPED_READ        = 8'h00;
    localparam logic       RESERVED_BIT         = 1'h0;

    // synchroniser depth for analog comparator flags
    localparam int         SYNC_STAGES          = 2;

endpackage

// >>> logic/flag_synchronizer.sv
`timescale 1ns/100ps
module flag_synchronizer #(
    parameter int STAGES = charger_regs_pkg::SYNC_STAGES,
    parameter int WIDTH  = 1
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             arst_n,
    // asynchronous levels in, synchronised levels out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_q [STAGES];
    logic [WIDTH-1:0] stage_d [STAGES];

    if (STAGES < 2) begin : g_bad_depth
        $error("flag_synchronizer needs at least two stages");
    end

    // the first stage feeds only the next stage; nothing else looks at it
    always_comb begin
        stage_d[0] = async_in;
        for (int i = 1; i < STAGES; i++) begin
            stage_d[i] = stage_q[i-1];
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < STAGES; i++) begin
                stage_q[i] <= '0;
            end
        end else begin
            stage_q <= stage_d;
        end
    end

    assign sync_out = stage_q[STAGES-1];

endmodule

// >>> logic/charger_input_limit_and_adc_regs.sv
`timescale 1ns/100ps
module charger_input_limit_and_adc_regs #(
    parameter int CODE_WIDTH = charger_regs_pkg::CODE_WIDTH
) (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       arst_n,
    // register port from the serial control interface
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rd_data,
    // register-defaults restore request and its completion
    input  wire logic       restore_req,
    output logic            restore_done,
    output logic            safety_timer_restart,
    // relative-threshold control
    input  wire logic       relative_update,
    input  wire logic [6:0] relative_code,
    // converter results, same clock domain
    input  wire logic       adc_valid,
    input  wire logic [6:0] battery_voltage_reading,
    input  wire logic [6:0] system_voltage_reading,
    input  wire logic [6:0] input_voltage_reading,
    input  wire logic [6:0] charge_current_reading,
    // analog comparator levels, asynchronous
    input  wire logic       thermal_regulation_flag,
    input  wire logic       input_attached_flag,
    input  wire logic       below_battery_short_threshold,
    // threshold handed to the input regulation loop
    output logic            absolute_threshold_select,
    output logic      [6:0] input_voltage_limit_threshold
);

    if (CODE_WIDTH != charger_regs_pkg::CODE_WIDTH) begin : g_bad_width
        $error("register layout fixes the code width at seven bits");
    end

    // clamp keeps the regulation point at or above the lowest legal code
    function automatic logic [6:0] clamp_code(input logic [6:0] code);
        clamp_code = (code < charger_regs_pkg::THRESHOLD_CLAMP_CODE) ?
                     charger_regs_pkg::THRESHOLD_CLAMP_CODE : code;
    endfunction

    function automatic logic [7:0] pack_reg(input logic flag, input logic [6:0] code);
        pack_reg = {flag, code};
    endfunction

    // synchronised comparator levels
    logic [2:0] flags_sync;
    logic       thermal_sync;
    logic       attached_sync;
    logic       short_sync;

    flag_synchronizer #(
        .STAGES (charger_regs_pkg::SYNC_STAGES),
        .WIDTH  (3)
    ) u_flag_sync (
        .clock    (clock),
        .arst_n   (arst_n),
        .async_in ({below_battery_short_threshold, input_attached_flag, thermal_regulation_flag}),
        .sync_out (flags_sync)
    );

    assign thermal_sync  = flags_sync[0];
    assign attached_sync = flags_sync[1];
    assign short_sync    = flags_sync[2];

    // state
    logic       select_q;
    logic       select_d;
    logic [6:0] threshold_q;
    logic [6:0] threshold_d;
    logic [6:0] battery_q;
    logic [6:0] battery_d;
    logic [6:0] system_q;
    logic [6:0] system_d;
    logic [6:0] input_q;
    logic [6:0] input_d;
    logic [6:0] current_q;
    logic [6:0] current_d;
    logic       done_q;
    logic       done_d;
    logic [7:0] rd_data_q;
    logic [7:0] rd_data_d;
    logic [6:0] effective_q;
    logic [6:0] effective_d;
    logic       limit_write;

    assign limit_write = reg_wr && (reg_addr == charger_regs_pkg::OFFSET_INPUT_LIMIT);

    always_comb begin
        select_d    = select_q;
        threshold_d = threshold_q;
        battery_d   = battery_q;
        system_d    = system_q;
        input_d     = input_q;
        current_d   = current_q;
        done_d      = 1'b0;
        // restore wins over host writes and internal updates
        if (restore_req) begin
            select_d    = charger_regs_pkg::SELECT_RESET;
            threshold_d = charger_regs_pkg::THRESHOLD_RESET_CODE;
            done_d      = 1'b1;
        end else begin
            if (limit_write) begin
                select_d = reg_wdata[charger_regs_pkg::FLAG_BIT];
            end
            if (select_q) begin
                if (limit_write) begin
                    threshold_d = reg_wdata[6:0];
                end
            end else if (relative_update) begin
                threshold_d = relative_code;
            end
        end
        // results follow the converter only; host writes never reach them
        if (adc_valid) begin
            battery_d = battery_voltage_reading;
            system_d  = system_voltage_reading;
            input_d   = input_voltage_reading;
            current_d = charge_current_reading;
        end
    end

    // regulation point: the loop decodes 2.6 V plus 100 mV per code step
    always_comb begin
        effective_d = clamp_code(threshold_d);
    end

    always_comb begin
        case (reg_addr)
            charger_regs_pkg::OFFSET_INPUT_LIMIT: begin
                rd_data_d = pack_reg(select_q, threshold_q);
            end
            charger_regs_pkg::OFFSET_BATTERY: begin
                rd_data_d = pack_reg(thermal_sync, battery_q);
            end
            charger_regs_pkg::OFFSET_SYSTEM: begin
                rd_data_d = pack_reg(charger_regs_pkg::RESERVED_BIT, system_q);
            end
            charger_regs_pkg::OFFSET_INPUT_VOLTAGE: begin
                rd_data_d = pack_reg(attached_sync, input_q);
            end
            charger_regs_pkg::OFFSET_CHARGE: begin
                // masked on read so a stale result never shows during a short
                rd_data_d = pack_reg(charger_regs_pkg::RESERVED_BIT,
                                     short_sync ? charger_regs_pkg::CURRENT_SHORT_CODE : current_q);
            end
            default: begin
                rd_data_d = charger_regs_pkg::UNMAPPED_READ;
            end
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            select_q    <= charger_regs_pkg::SELECT_RESET;
            threshold_q <= charger_regs_pkg::THRESHOLD_RESET_CODE;
            effective_q <= charger_regs_pkg::THRESHOLD_RESET_CODE;
            battery_q   <= charger_regs_pkg::RESULT_RESET_CODE;
            system_q    <= charger_regs_pkg::RESULT_RESET_CODE;
            input_q     <= charger_regs_pkg::RESULT_RESET_CODE;
            current_q   <= charger_regs_pkg::RESULT_RESET_CODE;
            done_q      <= 1'b0;
            rd_data_q   <= charger_regs_pkg::UNMAPPED_READ;
        end else begin
            select_q    <= select_d;
            threshold_q <= threshold_d;
            effective_q <= effective_d;
            battery_q   <= battery_d;
            system_q    <= system_d;
            input_q     <= input_d;
            current_q   <= current_d;
            done_q      <= done_d;
            rd_data_q   <= rd_data_d;
        end
    end

    assign reg_rd_data                   = rd_data_q;
    assign restore_done                  = done_q;
    assign safety_timer_restart          = done_q;
    assign absolute_threshold_select     = select_q;
    assign input_voltage_limit_threshold = effective_q;

    // checks

    a_reset_defaults: assert property (
        @(posedge clock) $rose(arst_n) |->
            (threshold_q == charger_regs_pkg::THRESHOLD_RESET_CODE) && !select_q)
        else $error("threshold register left reset with a wrong value");

    a_clamp_floor: assert property (
        @(posedge clock) disable iff (!arst_n)
        (threshold_q < charger_regs_pkg::THRESHOLD_CLAMP_CODE) |->
            (input_voltage_limit_threshold == charger_regs_pkg::THRESHOLD_CLAMP_CODE))
        else $error("effective threshold fell below the clamp");

    a_clamp_pass: assert property (
        @(posedge clock) disable iff (!arst_n)
        (threshold_q >= charger_regs_pkg::THRESHOLD_CLAMP_CODE) |->
            (input_voltage_limit_threshold == threshold_q))
        else $error("threshold at or above the clamp not passed through");

    a_relative_ignores_host: assert property (
        @(posedge clock) disable iff (!arst_n)
        (limit_write && !select_q && !relative_update && !restore_req) |=>
            threshold_q == $past(threshold_q))
        else $error("host write changed the field in relative mode");

    a_relative_update: assert property (
        @(posedge clock) disable iff (!arst_n)
        (relative_update && !select_q && !restore_req) |=>
            threshold_q == $past(relative_code))
        else $error("relative control did not update the field");

    a_absolute_write: assert property (
        @(posedge clock) disable iff (!arst_n)
        (limit_write && select_q && !restore_req) |=>
            (threshold_q == $past(reg_wdata[6:0])) &&
            (input_voltage_limit_threshold == clamp_code($past(reg_wdata[6:0]))))
        else $error("host write lost in absolute mode");

    a_select_write: assert property (
        @(posedge clock) disable iff (!arst_n)
        (limit_write && !restore_req) |=>
            (absolute_threshold_select == $past(reg_wdata[charger_regs_pkg::FLAG_BIT])))
        else $error("select bit did not follow the host write");

    a_absolute_holds: assert property (
        @(posedge clock) disable iff (!arst_n)
        (select_q && !limit_write && !restore_req) |=> $stable(threshold_q))
        else $error("field moved in absolute mode without a host write");

    a_restore_sequence: assert property (
        @(posedge clock) disable iff (!arst_n)
        restore_req |=> restore_done && safety_timer_restart && !select_q &&
            (threshold_q == charger_regs_pkg::THRESHOLD_RESET_CODE) ##1 (!restore_done || $past(restore_req)))
        else $error("restore did not return defaults and self-clear");

    a_restore_clears: assert property (
        @(posedge clock) disable iff (!arst_n)
        !restore_req |=> !restore_done && !safety_timer_restart)
        else $error("restore completion without a request");

    a_current_short: assert property (
        @(posedge clock) disable iff (!arst_n)
        (reg_addr == 8'h12) && short_sync |=> reg_rd_data == 8'h00)
        else $error("charge current visible below short threshold");

    a_reserved_zero: assert property (
        @(posedge clock) disable iff (!arst_n)
        ($past(reg_addr) == 8'h0F || $past(reg_addr) == 8'h12) |-> !reg_rd_data[7])
        else $error("reserved bit 7 read as one");

    a_battery_flag: assert property (
        @(posedge clock) disable iff (!arst_n)
        (reg_addr == 8'h0E) |=> reg_rd_data[7] == $past(thermal_sync))
        else $error("thermal flag not reflected in bit 7");

    a_attach_flag: assert property (
        @(posedge clock) disable iff (!arst_n)
        (reg_addr == 8'h11) |=> reg_rd_data[7] == $past(attached_sync))
        else $error("attach flag not reflected in bit 7");

    a_results_host_proof: assert property (
        @(posedge clock) disable iff (!arst_n)
        (reg_wr && !adc_valid) |=> $stable(battery_q) && $stable(system_q) &&
            $stable(input_q) && $stable(current_q))
        else $error("host write reached a read-only result");

    a_battery_capture: assert property (
        @(posedge clock) disable iff (!arst_n)
        adc_valid ##1 (reg_addr == 8'h0E) |=> reg_rd_data[6:0] == $past(battery_voltage_reading, 2))
        else $error("battery result not presented");

    a_system_capture: assert property (
        @(posedge clock) disable iff (!arst_n)
        adc_valid ##1 (reg_addr == charger_regs_pkg::OFFSET_SYSTEM) |=>
            reg_rd_data[6:0] == $past(system_voltage_reading, 2))
        else $error("system result not presented");

    a_input_capture: assert property (
        @(posedge clock) disable iff (!arst_n)
        adc_valid ##1 (reg_addr == charger_regs_pkg::OFFSET_INPUT_VOLTAGE) |=>
            reg_rd_data[6:0] == $past(input_voltage_reading, 2))
        else $error("input voltage result not presented");

    a_current_capture: assert property (
        @(posedge clock) disable iff (!arst_n)
        adc_valid ##1 ((reg_addr == charger_regs_pkg::OFFSET_CHARGE) && !short_sync) |=>
            reg_rd_data == {1'b0, $past(charge_current_reading, 2)})
        else $error("charge current result not presented above short threshold");

    a_results_reset: assert property (
        @(posedge clock) $rose(arst_n) |->
            (input_q == charger_regs_pkg::RESULT_RESET_CODE) &&
            (current_q == charger_regs_pkg::RESULT_RESET_CODE))
        else $error("converter results left reset with a wrong value");

endmodule

// >>> dv/host_model.sv
`timescale 1ns/100ps
module host_model (
    // clock
    input  wire logic       clock,
    // register port
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rd_data
);
    initial begin
        reg_addr  = 8'h00;
        reg_wr    = 1'h0;
        reg_wdata = 8'h00;
    end
    // field bits in relative mode are only sent to probe the refusal
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wr    <= 1'h1;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr    <= 1'h0;
        // stale data is inverted so it never passes for a fresh byte
        reg_wdata <= ~d;
    endtask
    // read data lands one edge after the address
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        @(posedge clock);
        #1 d = reg_rd_data;
    endtask
endmodule

// >>> dv/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic       clock;
    logic       arst_n;
    logic [7:0] reg_addr;
    logic       reg_wr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rd_data;
    logic       restore_req;
    logic       restore_done;
    logic       safety_timer_restart;
    logic       relative_update;
    logic [6:0] relative_code;
    logic       adc_valid;
    logic [6:0] bat_in;
    logic [6:0] sys_in;
    logic [6:0] vin_in;
    logic [6:0] ich_in;
    logic       therm_in;
    logic       attach_in;
    logic       short_in;
    logic       absolute_threshold_select;
    logic [6:0] input_voltage_limit_threshold;
    int         errors;
    int         check_count;
    int         m_sel, m_field, m_bat, m_sys, m_vin, m_ich, m_th, m_at, m_sh;
    logic [7:0] addrs [7] = '{8'h0D, 8'h0E, 8'h0F, 8'h11, 8'h12, 8'h10, 8'h13};

    charger_input_limit_and_adc_regs charger_input_limit_and_adc_regs_i (
        .clock(clock), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd_data(reg_rd_data), .restore_req(restore_req),
        .restore_done(restore_done), .safety_timer_restart(safety_timer_restart),
        .relative_update(relative_update), .relative_code(relative_code), .adc_valid(adc_valid),
        .battery_voltage_reading(bat_in), .system_voltage_reading(sys_in),
        .input_voltage_reading(vin_in), .charge_current_reading(ich_in),
        .thermal_regulation_flag(therm_in), .input_attached_flag(attach_in),
        .below_battery_short_threshold(short_in), .absolute_threshold_select(absolute_threshold_select),
        .input_voltage_limit_threshold(input_voltage_limit_threshold));
    host_model host_model_i (
        .clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd_data(reg_rd_data));

    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        case (a)
            charger_regs_pkg::OFFSET_INPUT_LIMIT:   return {m_sel[0], m_field[6:0]};
            charger_regs_pkg::OFFSET_BATTERY:       return {m_th[0], m_bat[6:0]};
            charger_regs_pkg::OFFSET_SYSTEM:        return {1'h0, m_sys[6:0]};
            charger_regs_pkg::OFFSET_INPUT_VOLTAGE: return {m_at[0], m_vin[6:0]};
            charger_regs_pkg::OFFSET_CHARGE:        return {1'h0, (m_sh != 0) ? 7'h00 : m_ich[6:0]};
            default:                                return 8'h00;
        endcase
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // first n registers read back, then the threshold handed to the loop
    task automatic chk_regs(input int n);
        logic [7:0] d;
        logic [6:0] eff;
        for (int i = 0; i < n; i++) begin
            host_model_i.rd(addrs[i], d);
            chk(d, exp_rd(addrs[i]), "register read");
        end
        eff = (m_field < 13) ? 7'h0D : m_field[6:0];
        chk({absolute_threshold_select, input_voltage_limit_threshold}, {m_sel[0], eff}, "threshold out");
    endtask
    task automatic pulse_rel(input logic [6:0] c);
        @(posedge clock);
        relative_update <= 1'h1;
        relative_code   <= c;
        @(posedge clock);
        relative_update <= 1'h0;
        relative_code   <= ~c;
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        clock = 1'h0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        #100000;
        errors++;
        complete_run();
    end
    initial begin
        {arst_n, restore_req, relative_update, relative_code, adc_valid} = '0;
        {bat_in, sys_in, vin_in, ich_in, therm_in, attach_in, short_in} = '0;
        {m_sel, m_bat, m_sys, m_vin, m_ich, m_th, m_at, m_sh} = '0;
        m_field = 8'h12;
        errors = 0;
        check_count = 0;
        void'($urandom(43));
        repeat (2) @(posedge clock);
        arst_n <= 1'h1;
        chk_regs(7);
        for (int i = 0; i < 4; i++) begin
            host_model_i.wr(8'h0D, 8'(($urandom & 8'h7F) | 8'h01));
            chk_regs(1);
            m_field = (i == 0) ? 0 : $urandom_range(0, 127);
            pulse_rel(7'(m_field));
            chk_regs(1);
        end
        // the field is only taken once the select bit already stands
        host_model_i.wr(8'h0D, 8'h80);
        for (int i = 0; i < 6; i++) begin
            m_field = (i < 3) ? 12 + i : (i == 3) ? 127 : $urandom_range(0, 127);
            m_sel = 1;
            host_model_i.wr(8'h0D, 8'h80 | 8'(m_field));
            pulse_rel(7'(~m_field));
            chk_regs(1);
        end
        // mid-run reset from absolute mode must bring back the defaults
        @(posedge clock);
        arst_n <= 1'h0;
        @(posedge clock);
        arst_n <= 1'h1;
        {m_sel, m_field} = {32'd0, 32'h12};
        chk_regs(7);
        for (int i = 0; i < 8; i++) begin
            {m_bat, m_sys, m_vin, m_ich} = {4{$urandom_range(0, 127)}} ^ {32'd0, 32'd5, 32'd9, 32'd3};
            {m_th, m_at, m_sh} = {$urandom_range(0, 1), $urandom_range(0, 1), int'(i[0])};
            @(posedge clock);
            {bat_in, sys_in, vin_in, ich_in} <= {7'(m_bat), 7'(m_sys), 7'(m_vin), 7'(m_ich)};
            {therm_in, attach_in, short_in, adc_valid} <= {m_th[0], m_at[0], m_sh[0], 1'h1};
            @(posedge clock);
            adc_valid <= 1'h0;
            host_model_i.wr(addrs[1 + i % 4], 8'($urandom));
            chk_regs(5);
        end
        host_model_i.wr(8'h0D, 8'h80);
        host_model_i.wr(8'h0D, 8'hA5);
        {m_sel, m_field} = {32'd1, 32'h25};
        chk_regs(1);
        @(posedge clock);
        restore_req <= 1'h1;
        @(posedge clock);
        restore_req <= 1'h0;
        #1 chk({6'h00, restore_done, safety_timer_restart}, 8'h03, "restore pulse");
        @(posedge clock);
        #1 chk({6'h00, restore_done, safety_timer_restart}, 8'h00, "restore end");
        {m_sel, m_field} = {32'd0, 32'h12};
        chk_regs(1);
        complete_run();
    end
endmodule
